// *** include/divider_pkg.sv ***
package divider_pkg;
  // Register byte offsets
  localparam logic [7:0] ctrl_offset = 8'h00;
  localparam logic [7:0] status_offset = 8'h04;
  // Control field positions
  localparam int ctrl_preset_lsb = 0;
  localparam int ctrl_preset_msb = 7;
  localparam int ctrl_low_bcd_bit = 8;
  localparam int ctrl_high_bcd_bit = 9;
  localparam int ctrl_cascade_bit = 10;
  // Status field positions
  localparam int status_count_lsb = 0;
  localparam int status_count_msb = 7;
  localparam int status_zero_bit = 8;
  localparam int status_q_bit = 9;
  // Reset values
  localparam logic [7:0] preset_reset = 8'h00;
  localparam logic low_bcd_reset = 1'b0;
  localparam logic high_bcd_reset = 1'b0;
  localparam logic cascade_reset = 1'b1;
  localparam logic [7:0] count_reset = 8'h01;
  // Count value that triggers a reload
  localparam logic [7:0] reload_count = 8'h01;
  // Stage limits
  localparam logic [3:0] binary_top = 4'hF;
  localparam logic [3:0] bcd_top = 4'h9;
  localparam logic [7:0] max_ratio_load = 8'h00;
endpackage

// *** rtl/nibble_stage.sv ***
// One 4-bit down-counting stage, binary or decade
module nibble_stage (
  input wire logic [3:0] value,
  input wire logic bcd,
  input wire logic borrow_in,
  output logic [3:0] next_value,
  output logic borrow_out
);
  wire logic at_zero;
  wire logic [3:0] top;

  // Stage wraps from zero to its top digit and lends a borrow upward
  assign at_zero = (value == 4'h0);
  assign top = bcd ? divider_pkg::bcd_top : divider_pkg::binary_top;  // see RULE9
  assign borrow_out = borrow_in & at_zero;
  assign next_value = !borrow_in ? value : (at_zero ? top : value - 4'h1);
endmodule

// *** rtl/divide_by_n.sv ***
// Functional notes
// RULE1 - Binary/binary, feedback high, preset zero divides by 256 on both outputs.
// RULE2 - Preset of one is illegal and must never be programmed.
// RULE3 - Preset two is the minimum, dividing by two; Q stays low.
// RULE4 - Binary/binary Q active only for ratios 128 and above.
// RULE5 - Binary/binary preset weights 128 down to 1; ratio equals preset.
// RULE6 - Low BCD, high binary: weights 80..10 plus digit; zero gives 160.
// RULE7 - Low stage BCD: Q active from ratio 80 when top bit set.
// RULE8 - Low binary, high BCD: digit times 16; zero gives 160; Q from 128.
// RULE9 - Both BCD: two decimal digits; zero gives 100; Q from 80.
// RULE10 - Count decrements by one on each rising input clock edge.
// RULE11 - Reload preset when count one seen; one zero pulse per N clocks.
// RULE12 - Each stage select: high chooses BCD, low chooses binary.
// RULE13 - Feedback low inhibits preset loading; maximum ratio for the modes.
// RULE14 - Q follows the most significant flip-flop of the upper stage.
//
// Added by the designer: the register offsets and register access over APB.
module divide_by_n (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic count_clk,
  output logic zero_detect,
  output logic q_out
);
  logic [7:0] preset_word;
  logic low_stage_bcd_select;
  logic high_stage_bcd_select;
  logic cascade_feedback;
  logic [7:0] count;
  logic [2:0] clk_sync;
  logic clk_level;

  wire logic access;
  wire logic commit;
  wire logic hit_ctrl;
  wire logic hit_status;
  wire logic mapped;
  wire logic [31:0] ctrl_view;
  wire logic [31:0] status_view;
  wire logic [31:0] next_prdata;
  wire logic step;
  wire logic reload;
  wire logic [7:0] load_value;
  wire logic [3:0] low_dec;
  wire logic [3:0] high_dec;
  wire logic low_borrow;
  wire logic [7:0] next_count;
  wire logic answer_now;
  wire logic read_answer;
  wire logic error_answer;
  wire logic write_ctrl;
  wire logic clk_agree;
  wire logic [3:0] count_low;
  wire logic [3:0] count_high;
  wire logic zero_next;
  wire logic q_next;

  // APB decode; one wait state, pready comes from a flop
  assign access = psel & penable;
  assign commit = access & pready;
  assign hit_ctrl = (paddr == divider_pkg::ctrl_offset);
  assign hit_status = (paddr == divider_pkg::status_offset);
  assign mapped = hit_ctrl | hit_status;
  assign ctrl_view = {21'h000000, cascade_feedback, high_stage_bcd_select,
                      low_stage_bcd_select, preset_word};
  assign status_view = {22'h000000, q_out, zero_detect, count};
  assign next_prdata = hit_ctrl ? ctrl_view : (hit_status ? status_view : 32'h00000000);

  // Answer and write strobes
  assign answer_now = access & ~pready;
  assign read_answer = answer_now & ~pwrite;
  assign error_answer = answer_now & ~mapped;
  assign write_ctrl = commit & pwrite & hit_ctrl;

  // Ready pulse after one wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else if (clk_en) begin
      pready <= answer_now;
    end
  end

  // Read data, zero outside a read answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (clk_en) begin
      prdata <= read_answer ? next_prdata : 32'h00000000;
    end
  end

  // Error answer for an unmapped address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pslverr <= error_answer;
    end
  end

  // Preset word, taken at the completing access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      preset_word <= divider_pkg::preset_reset;
    end else if (clk_en && write_ctrl) begin
      preset_word <= pwdata[divider_pkg::ctrl_preset_msb:divider_pkg::ctrl_preset_lsb];
    end
  end

  // Lower stage mode select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_stage_bcd_select <= divider_pkg::low_bcd_reset;
    end else if (clk_en && write_ctrl) begin
      low_stage_bcd_select <= pwdata[divider_pkg::ctrl_low_bcd_bit];  // see RULE12
    end
  end

  // Upper stage mode select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_stage_bcd_select <= divider_pkg::high_bcd_reset;
    end else if (clk_en && write_ctrl) begin
      high_stage_bcd_select <= pwdata[divider_pkg::ctrl_high_bcd_bit];  // see RULE12
    end
  end

  // Cascade feedback, high after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cascade_feedback <= divider_pkg::cascade_reset;
    end else if (clk_en && write_ctrl) begin
      cascade_feedback <= pwdata[divider_pkg::ctrl_cascade_bit];
    end
  end

  // Three-flop synchroniser for the counted clock pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_sync <= 3'h0;
    end else if (clk_en) begin
      clk_sync <= {clk_sync[1:0], count_clk};
    end
  end

  // Second and third stages agree on one level
  assign clk_agree = (clk_sync[1] == clk_sync[2]);

  // Settled pin level, moved only on agreement
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_level <= 1'b0;
    end else if (clk_en && clk_agree) begin
      clk_level <= clk_sync[2];
    end
  end

  // Counted edge once the agreed level turns high
  assign step = clk_agree & clk_sync[2] & ~clk_level;  // see RULE10

  // Counter split into its two stages
  assign count_low = count[3:0];
  assign count_high = count[7:4];

  // Lower stage always borrows on a step; upper takes its borrow
  nibble_stage low_stage (
    .value(count_low),
    .bcd(low_stage_bcd_select),  // see RULE6
    .borrow_in(1'b1),
    .next_value(low_dec),
    .borrow_out(low_borrow)
  );

  nibble_stage high_stage (
    .value(count_high),
    .bcd(high_stage_bcd_select),  // see RULE8
    .borrow_in(low_borrow),
    .next_value(high_dec),
    .borrow_out()
  );

  // Reload on count one; zero load wraps through the full modulus
  assign reload = (count == divider_pkg::reload_count);  // see RULE11
  assign load_value = cascade_feedback ? preset_word : divider_pkg::max_ratio_load;  // see RULE13
  assign next_count = reload ? load_value : {high_dec, low_dec};  // see RULE1

  // Output levels for the value about to be taken
  assign zero_next = (next_count == divider_pkg::reload_count);  // see RULE3
  assign q_next = next_count[7];  // see RULE4 RULE7 RULE14

  // Counter, advanced on a counted edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= divider_pkg::count_reset;
    end else if (clk_en && step) begin
      count <= next_count;  // see RULE5
    end
  end

  // Zero detect, high while a counted edge has left the count at one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zero_detect <= 1'b0;
    end else if (clk_en && step) begin
      zero_detect <= zero_next;  // see RULE11
    end
  end

  // Q output follows the top counter bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_out <= 1'b0;
    end else if (clk_en && step) begin
      q_out <= q_next;
    end
  end
endmodule

// *** testbench/div_monitor.sv ***
module div_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic count_clk,
  input wire logic zero_detect,
  input wire logic q_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn || !clk_en);
  // Bus answer timing and error code
  a_ready_after_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready missing after wait state");
  a_ready_one_cycle: assert property (pready |=> !pready) else $error("pready too long");
  a_err_unmapped: assert property (pready |-> pslverr == (paddr != 8'h00 && paddr != 8'h04))
    else $error("pslverr wrong for address");
  a_err_with_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
  a_rdata_idle: assert property (!pready || pwrite |-> prdata == 32'h0000_0000)
    else $error("prdata not zero outside read answer");
  // Divided outputs
  a_zero_one_period: assert property (
    $rose(zero_detect) |-> zero_detect[*8] ##1 !zero_detect)
    else $error("zero pulse not one count period");
  a_zero_gap: assert property ($fell(zero_detect) |-> !zero_detect[*8])
    else $error("zero pulses too close");
  a_out_on_edge: assert property (
    $changed(zero_detect) || $changed(q_out) |-> $past(count_clk))
    else $error("output moved without counted edge");
  // Main scenarios
  cover property ($rose(q_out));
  cover property (pslverr);
  cover property ($rose(zero_detect) ##8 !zero_detect);
endmodule

// *** testbench/count_source.sv ***
module count_source (
  input wire logic pclk,
  output logic count_clk
);
  timeunit 1ns;
  timeprecision 1ns;
  int n = 0;
  // Counted clock, four pclk high and four low
  always @(posedge pclk) begin
    n <= n + 1;
    count_clk <= n[2];
  end
endmodule

// *** testbench/testbench.sv ***
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er, clk_en = 1;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, count_clk, zero_detect, q_out;
  int err_total = 0, n_tests = 0, cyc = 0, q_rises = 0;
  count_source u_src (.pclk, .count_clk);
  divide_by_n u_dut (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .count_clk, .zero_detect, .q_out);
  // Clock, q edge count and hang limit
  initial forever #5 pclk = ~pclk;
  always @(posedge q_out) q_rises++;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_total++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("tests=%0d errors=%0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer, held until pready
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Program control, then time one zero period and count q edges in it
  task automatic run(input logic [10:0] c, input int n, q);
    time t;
    int a;
    bus(8'h00, 1'b1, {21'h0, c}, rd, er);
    repeat (2) @(posedge zero_detect);
    a = q_rises;
    t = $time;
    @(posedge zero_detect);
    chk(32'(($time - t) / 10), 32'(n * 8));
    chk(32'(q_rises - a), 32'(q));
  endtask
  task automatic t_regs();
    bus(8'h04, 1'b0, 32'h0, rd, er);
    chk(rd, 32'h0000_0001);
    bus(8'h00, 1'b0, 32'h0, rd, er);
    chk(rd, 32'h0000_0400);
    bus(8'h00, 1'b1, 32'h0000_047F, rd, er);
    bus(8'h04, 1'b1, 32'hFFFF_FFFF, rd, er);
    chk(32'(er), 32'h0);
    bus(8'h00, 1'b0, 32'h0, rd, er);
    chk(rd, 32'h0000_047F);
    bus(8'h08, 1'b1, 32'h1, rd, er);
    chk(32'(er), 32'h1);
    $display("register test done");
  endtask
  task automatic t_bin();
    run(11'h400, 256, 1);
    run(11'h402, 2, 0);
    run(11'h47F, 127, 0);
    run(11'h480, 128, 1);
    $display("binary test done");
  endtask
  task automatic t_bcd();
    run(11'h500, 160, 1);
    run(11'h580, 80, 1);
    run(11'h69F, 159, 1);
    run(11'h799, 99, 1);
    $display("decade test done");
  endtask
  task automatic t_hold();
    run(11'h037, 256, 1);
    run(11'h305, 100, 1);
    $display("hold test done");
  endtask
  // Clock enable low freezes a zero pulse past its count period
  task automatic t_freeze();
    bus(8'h00, 1'b1, 32'h0000_0402, rd, er);
    repeat (2) @(posedge zero_detect);
    clk_en <= 1'b0;
    repeat (40) @(posedge pclk);
    chk(32'(zero_detect), 32'h1);
    clk_en <= 1'b1;
    @(negedge zero_detect);
    $display("freeze test done");
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_bin();
    t_bcd();
    t_hold();
    t_freeze();
    give_verdict();
  end
endmodule
bind divide_by_n div_monitor u_mon (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr,
  .prdata, .pready, .pslverr, .count_clk, .zero_detect, .q_out);
